// [verification/oam_mem.sv]
// Data memory model, location i preset to i
`timescale 1ns/1ps
module oam_mem
(
   input wire logic sys_clk_i,
   input wire logic [6:0] raddr_i,
   input wire oam_pkg::oam_mem_wr_s wr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [128];
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
   assign rdata_o = mem[raddr_i];
   always @(posedge sys_clk_i) if (wr_i.wr) mem[wr_i.addr] <= wr_i.data;
endmodule

// [verification/oam_props.sv]
// Checker for the executor
`timescale 1ns/1ps
module oam_props
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire oam_pkg::oam_instr_s instr_i,
   input wire logic [7:0] mem_rdata_i,
   input wire oam_pkg::oam_mem_wr_s mem_wr_o,
   input wire logic [7:0] acc_o,
   input wire logic zero_o,
   input wire logic zero_upd_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_or_to_acc: assert property (instr_i.valid && instr_i.word[13:7] == 7'h08 |=>
      !mem_wr_o.wr && acc_o == ($past(acc_o) | $past(mem_rdata_i))) else $error("or to acc");
   a_or_to_mem: assert property (instr_i.valid && instr_i.word[13:7] == 7'h09 |=>
      mem_wr_o.wr && mem_wr_o.data == ($past(acc_o) | $past(mem_rdata_i))) else $error("or wr");
   a_copy_zero: assert property (instr_i.valid && instr_i.word[13:8] == 6'h08 |=>
      zero_o == ($past(mem_rdata_i) == 8'h00)) else $error("copy zero");
   a_const_acc: assert property (instr_i.valid && instr_i.word[13:10] == 4'hc |=>
      acc_o == $past(instr_i.word[7:0]) && $stable(zero_o)) else $error("const load");
   a_or_zero: assert property (instr_i.valid && instr_i.word[13:8] == 6'h04 |=>
      zero_upd_o && zero_o == (($past(acc_o) | $past(mem_rdata_i)) == 8'h00))
      else $error("or zero");
   a_copy_to_acc: assert property (instr_i.valid && instr_i.word[13:7] == 7'h10 |=>
      !mem_wr_o.wr && acc_o == $past(mem_rdata_i)) else $error("copy to acc");
   a_copy_to_mem: assert property (instr_i.valid && instr_i.word[13:7] == 7'h11 |=>
      mem_wr_o.wr && mem_wr_o.addr == $past(instr_i.word[6:0])
      && mem_wr_o.data == $past(mem_rdata_i) && acc_o == $past(acc_o)) else $error("copy wr");
endmodule
bind oam_exec oam_props u_props(.*);

// [verification/or_and_move_instruction_exec_test.sv]
// Directed bench for the executor
`timescale 1ns/1ps
module or_and_move_instruction_exec_test;
   logic sys_clk_i = 0, rst_b_i = 0, zero_o;
   oam_pkg::oam_instr_s instr_i = '0;
   oam_pkg::oam_mem_wr_s wr;
   logic [7:0] rd, acc_o;
   logic [6:0] ra;
   logic upd;
   int mismatches = 0, samples_checked = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   oam_mem u_mem(.sys_clk_i(sys_clk_i), .raddr_i(ra), .wr_i(wr), .rdata_o(rd));
   oam_exec u_dut(.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i), .mem_rdata_i(rd),
      .mem_raddr_o(ra), .mem_wr_o(wr), .acc_o(acc_o), .zero_o(zero_o), .zero_upd_o(upd));
   // Write data and address are only meaningful while the strobe is up
   task automatic run(input logic [13:0] w, input logic [7:0] a, input logic [8:0] m, input logic z,
      input logic u);
      @(posedge sys_clk_i) instr_i <= {1'b1, w};
      @(posedge sys_clk_i) instr_i <= '0;
      #1 samples_checked++;
      if ({acc_o, wr.wr, wr.wr ? wr.data : 8'h00, wr.wr ? wr.addr : 7'h00, zero_o, upd} !==
         {a, m, m[8] ? w[6:0] : 7'h00, z, u})
      begin
         mismatches++;
         $display("wrong value %0t word %h", $time, w);
      end
   endtask
   task final_report;
      $display("checked %0d wrong %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task t_const;
      run(14'h335a, 8'h5a, 9'h000, 1'b0, 1'b0);
      $display("const done");
   endtask
   task t_or;
      run(14'h0405, 8'h5f, 9'h000, 1'b0, 1'b1);
      run(14'h0483, 8'h5f, 9'h15f, 1'b0, 1'b1);
      run(14'h0a85, 8'h5f, 9'h000, 1'b0, 1'b0);
      $display("or done");
   endtask
   task t_copy;
      run(14'h0880, 8'h5f, 9'h100, 1'b1, 1'b1);
      run(14'h3100, 8'h00, 9'h000, 1'b1, 1'b0);
      run(14'h0803, 8'h5f, 9'h000, 1'b0, 1'b1);
      $display("copy done");
   endtask
   task t_reset;
      @(posedge sys_clk_i) rst_b_i <= 1'b0;
      #1 samples_checked++;
      if ({acc_o, wr.wr, zero_o, upd} !== 11'h000)
      begin
         mismatches++;
         $display("wrong value %0t reset", $time);
      end
      @(posedge sys_clk_i) rst_b_i <= 1'b1;
      run(14'h3012, 8'h12, 9'h000, 1'b0, 1'b0);
      $display("reset done");
   endtask
   initial
   begin
      repeat (6) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      t_const();
      t_or();
      t_copy();
      t_reset();
      final_report();
   end
   initial
   begin
      #2000 mismatches++;
      final_report();
   end
endmodule

// [verilog/oam_defines.svh]
// Constants for the OR / copy / constant-load executor
// Summary of operation
// RULE1: OR-into-memory ORs accumulator with addressed location; nil-result bit follows result.
// RULE2: OR-into-memory with target bit clear writes accumulator, memory untouched.
// RULE3: OR-into-memory with target bit set writes result back to memory.
// RULE4: Copy-location reads addressed location and moves value unchanged.
// RULE5: Copy-location goes to accumulator when target bit 0, memory when 1.
// RULE6: Copy-location updates nil-result bit from moved value.
// RULE7: Constant-load puts 8-bit immediate in accumulator; status untouched; bits 9:8 ignored.
`ifndef OAM_DEFINES_SVH
`define OAM_DEFINES_SVH
`define OAM_OP_OR_MEM 6'h04
`define OAM_OP_COPY 6'h08
`define OAM_OP_CONST 4'hc
`define OAM_OPC_HI 13
`define OAM_OPC_LO 8
`define OAM_CONST_HI 13
`define OAM_CONST_LO 10
`define OAM_DEST_BIT 7
`define OAM_ADDR_HI 6
`define OAM_ADDR_LO 0
`define OAM_LIT_HI 7
`define OAM_LIT_LO 0
`define OAM_ZERO_BYTE 8'h00
`define OAM_ACC_RST 8'h00
`endif

// [verilog/oam_exec.sv]
// Executor for OR-into-memory, copy-location and constant-load
`timescale 1ns/1ps
`include "oam_defines.svh"
module oam_exec
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire oam_pkg::oam_instr_s instr_i,
   input wire logic [7:0] mem_rdata_i,
   output logic [6:0] mem_raddr_o,
   output oam_pkg::oam_mem_wr_s mem_wr_o,
   output logic [7:0] acc_o,
   output logic zero_o,
   output logic zero_upd_o
);
   // Fields of the incoming word
   logic [5:0] opc;
   logic [3:0] const_opc;
   logic dest;
   logic [6:0] addr;
   logic [7:0] lit;
   // Decode strobes, all gated by valid
   logic is_or;
   logic is_copy;
   logic is_const;
   logic writes_status;
   logic writes_acc;
   logic writes_mem;
   // Shared result path
   logic [7:0] result;
   logic result_nil;
   // Accumulator group
   logic [7:0] acc;
   logic [7:0] next_acc;
   // Nil-result group
   logic zero;
   logic next_zero;
   // Update pulse group
   logic zero_upd;
   logic next_zero_upd;
   // Memory write-back groups
   logic wr_stb;
   logic next_wr_stb;
   logic [6:0] wr_addr;
   logic [6:0] next_wr_addr;
   logic [7:0] wr_data;
   logic [7:0] next_wr_data;

   always_comb
   begin
      opc = instr_i.word[`OAM_OPC_HI:`OAM_OPC_LO];
      const_opc = instr_i.word[`OAM_CONST_HI:`OAM_CONST_LO];
      dest = instr_i.word[`OAM_DEST_BIT];
      addr = instr_i.word[`OAM_ADDR_HI:`OAM_ADDR_LO];
      lit = instr_i.word[`OAM_LIT_HI:`OAM_LIT_LO];
   end

   // Read address is combinational so data returns in the same cycle;
   // the fetch stage must hold the word stable for the whole cycle
   assign mem_raddr_o = addr;

   always_comb
   begin
      is_or = 1'b0;
      is_copy = 1'b0;
      is_const = 1'b0;
      if (instr_i.valid)
      begin
         is_or = (opc == `OAM_OP_OR_MEM); // RULE1
         is_copy = (opc == `OAM_OP_COPY); // RULE4
         // Low two opcode bits are don't-care
         is_const = (const_opc == `OAM_OP_CONST); // RULE7
      end
   end

   // Both file-register instructions share routing; only the operand differs
   always_comb
   begin
      writes_status = is_or || is_copy;
      writes_acc = 1'b0;
      writes_mem = 1'b0;
      if (writes_status)
      begin
         if (dest)
         begin
            writes_mem = 1'b1; // RULE3 RULE5
         end
         else
         begin
            writes_acc = 1'b1; // RULE2 RULE5
         end
      end
   end

   // Accumulator comes from its register, so back-to-back ops chain
   always_comb
   begin
      if (is_or)
      begin
         result = acc | mem_rdata_i; // RULE1
      end
      else
      begin
         result = mem_rdata_i; // RULE4
      end
      result_nil = (result == `OAM_ZERO_BYTE); // RULE1 RULE6
   end

   always_comb
   begin
      next_acc = acc;
      if (writes_acc)
      begin
         next_acc = result; // RULE2 RULE5
      end
      else if (is_const)
      begin
         next_acc = lit; // RULE7
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         acc <= `OAM_ACC_RST;
      end
      else
      begin
         acc <= next_acc;
      end
   end

   // Constant-load leaves the nil-result bit alone
   always_comb
   begin
      if (writes_status)
      begin
         next_zero = result_nil; // RULE1 RULE6
      end
      else
      begin
         next_zero = zero;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         zero <= 1'b0;
      end
      else
      begin
         zero <= next_zero;
      end
   end

   // Pulse tells the status register to take zero_o this cycle
   always_comb
   begin
      next_zero_upd = writes_status; // RULE1 RULE6
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         zero_upd <= 1'b0;
      end
      else
      begin
         zero_upd <= next_zero_upd;
      end
   end

   // Strobe is a one-cycle pulse per write-back
   always_comb
   begin
      next_wr_stb = writes_mem; // RULE3 RULE5
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_stb <= 1'b0;
      end
      else
      begin
         wr_stb <= next_wr_stb;
      end
   end

   // Payload parked at zero between writes so the bus stays quiet
   always_comb
   begin
      next_wr_addr = '0;
      next_wr_data = '0;
      if (writes_mem)
      begin
         next_wr_addr = addr;
         next_wr_data = result; // RULE3 RULE5
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_addr <= '0;
         wr_data <= '0;
      end
      else
      begin
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   assign acc_o = acc;
   assign zero_o = zero;
   assign zero_upd_o = zero_upd;
   assign mem_wr_o = {wr_stb, wr_addr, wr_data};
endmodule

// [verilog/oam_pkg.sv]
// Types for the OR / copy / constant-load executor
package oam_pkg;
   typedef enum logic [1:0] {OAM_IDLE, OAM_EXEC} oam_state_e;
   typedef struct packed {
      logic valid;
      logic [13:0] word;
   } oam_instr_s;
   typedef struct packed {
      logic wr;
      logic [6:0] addr;
      logic [7:0] data;
   } oam_mem_wr_s;
endpackage
